// *** src/msad_decoder.sv ***
`timescale 1ns/1ps
module msad_decoder
	import msad_pkg::*;
#(
	parameter int RF_LOCS    = MSAD_RF_LOCS,
	parameter int SFR_LOCS   = MSAD_SFR_LOCS,
	parameter int BANK_COUNT = MSAD_BANK_COUNT
)
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        external_access_select,
	input  wire logic        acc_valid,
	input  wire logic [2:0]  acc_kind,
	input  wire logic [23:0] acc_addr,
	input  wire logic        acc_write,
	input  wire logic        acc_bit,
	input  wire logic [7:0]  acc_wdata,
	input  wire logic        bank_select_high,
	input  wire logic        bank_select_low,
	input  wire logic        rf_valid,
	input  wire logic [5:0]  rf_loc,
	output logic             sel_bank,
	output logic             sel_ram,
	output logic             sel_code,
	output logic             sel_ext,
	output logic             sel_sfr,
	output logic             sel_rsvd,
	output logic             sel_bit_ok,
	output logic             sel_write_en,
	output logic             sel_fault,
	output logic [23:0]      mem_addr,
	output logic [8:0]       sfr_addr,
	output logic             rf_in_mem,
	output logic [23:0]      rf_mem_addr,
	output logic [7:0]       region_byte,
	output logic [23:0]      fetch_start
);

	// Refuse a geometry that the fixed decode cannot serve
	if (RF_LOCS != MSAD_RF_LOCS || SFR_LOCS != MSAD_SFR_LOCS ||
		BANK_COUNT != MSAD_BANK_COUNT)
	begin : g_geometry_check
		$error("msad_decoder decode is fixed to the documented geometry");
	end

	// Region byte and strap state
	logic [7:0]  region_r;
	logic [7:0]  region_nxt;
	logic        ea_r;
	logic        ea_nxt;
	logic        rst_seen_r;
	logic        rst_seen_nxt;

	// Reset fetch address, held in a flop
	logic [23:0] fetch_r;
	logic [23:0] fetch_nxt;

	// Registered outputs
	logic [6:0]  sel_nxt;
	logic        bit_nxt;
	logic        wen_nxt;
	logic        fault_nxt;
	logic [23:0] maddr_nxt;
	logic [8:0]  saddr_nxt;
	logic        rfm_nxt;
	logic [23:0] rfa_nxt;
	logic [6:0]  sel_r;
	logic        bit_r;
	logic        wen_r;
	logic        fault_r;
	logic [23:0] maddr_r;
	logic [8:0]  saddr_r;
	logic        rfm_r;
	logic [23:0] rfa_r;

	// Offset inside a closed span
	function automatic logic in_span(input logic [15:0] off, input logic [15:0] lo,
		input logic [15:0] hi);
		in_span = off >= lo && off <= hi;
	endfunction

	// Region outside the four usable ones
	function automatic logic is_reserved(input logic [7:0] rg);
		is_reserved = rg != MSAD_REGION_ZERO && rg != MSAD_REGION_ONE &&
			rg != MSAD_REGION_FE && rg != MSAD_REGION_TOP;
	endfunction

	// Byte offset placed at the bottom of region zero
	function automatic logic [23:0] legacy_internal(input logic [7:0] off);
		legacy_internal = {MSAD_REGION_ZERO, 8'h00, off};
	endfunction

	// Legacy data kinds, which must not reach code memory
	function automatic logic legacy_data(input logic [2:0] k);
		legacy_data = k == MSAD_ACC_EXT_MOVE || k == MSAD_ACC_LEG_DIRECT ||
			k == MSAD_ACC_LEG_INDIR;
	endfunction

	// Write landing on the region byte at its special-function address
	function automatic logic region_write(input logic [2:0] k, input logic [23:0] a);
		region_write = 1'b0;
		if (k == MSAD_ACC_LEG_DIRECT && {1'b0, a[7:0]} == MSAD_SFR_REGION_ADDR)
			region_write = 1'b1;
		else if (k > MSAD_ACC_LEG_INDIR && a[8:0] == MSAD_SFR_REGION_ADDR)
			region_write = 1'b1;
	endfunction

	// Decode a flat address into a target
	function automatic msad_tgt_t mem_target(input logic [23:0] a, input logic fetch,
		input logic ea);
		logic [7:0]  rg;
		logic [15:0] off;
		rg  = a[23:16];
		off = a[15:0];
		mem_target = MSAD_TGT_EXT;
		if (rg == MSAD_REGION_ZERO && in_span(off, MSAD_BANK_FIRST, MSAD_BANK_LAST))
			mem_target = MSAD_TGT_BANK;
		else if (rg == MSAD_REGION_ZERO && in_span(off, MSAD_RAM_FIRST, MSAD_RAM_LAST))
			mem_target = fetch ? MSAD_TGT_EXT : MSAD_TGT_RAM;
		else if (rg == MSAD_REGION_TOP && in_span(off, MSAD_CODE_FIRST, MSAD_CODE_LAST))
			mem_target = ea ? MSAD_TGT_CODE : MSAD_TGT_EXT;
		else if (is_reserved(rg))
			mem_target = MSAD_TGT_RSVD;
	endfunction

	// Region byte writes, strap capture at reset release, fetch start hold
	always_comb
	begin
		region_nxt   = region_r;
		ea_nxt       = ea_r;
		rst_seen_nxt = 1'b1;
		fetch_nxt    = fetch_r;
		if (!rst_seen_r)
			ea_nxt = external_access_select;
		if (acc_valid && acc_write && region_write(acc_kind, acc_addr))
			region_nxt = acc_wdata;
	end

	// Region, strap and fetch start registers
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			region_r   <= MSAD_REGION_RESET;
			ea_r       <= 1'b0;
			rst_seen_r <= 1'b0;
			fetch_r    <= MSAD_RESET_FETCH;
		end
		else
		begin
			region_r   <= region_nxt;
			ea_r       <= ea_nxt;
			rst_seen_r <= rst_seen_nxt;
			fetch_r    <= fetch_nxt;
		end
	end

	// Access decode
	always_comb
	begin
		msad_tgt_t   t;
		logic [23:0] a;
		t         = MSAD_TGT_NONE;
		a         = acc_addr;
		saddr_nxt = 9'h000;
		fault_nxt = 1'b0;
		case (msad_acc_t'(acc_kind))
			MSAD_ACC_FETCH:
			begin
				t = mem_target(a, 1'b1, ea_r);
			end
			MSAD_ACC_DATA:
			begin
				t = mem_target(a, 1'b0, ea_r);
			end
			MSAD_ACC_CODE_READ:
			begin
				a = {MSAD_REGION_TOP, acc_addr[15:0]};
				t = mem_target(a, 1'b0, ea_r);
			end
			MSAD_ACC_EXT_MOVE:
			begin
				a = {region_r, acc_addr[15:0]};
				t = mem_target(a, 1'b0, ea_r);
			end
			MSAD_ACC_LEG_DIRECT:
			begin
				if (acc_addr[7:0] >= MSAD_LEGACY_SFR_BASE)
				begin
					t         = MSAD_TGT_SFR;
					saddr_nxt = MSAD_SFR_LEGACY_BASE | {1'b0, acc_addr[7:0]};
				end
				else
				begin
					a = legacy_internal(acc_addr[7:0]);
					t = mem_target(a, 1'b0, ea_r);
				end
			end
			MSAD_ACC_LEG_INDIR:
			begin
				a = legacy_internal(acc_addr[7:0]);
				t = mem_target(a, 1'b0, ea_r);
			end
			default:
			begin
				t         = MSAD_TGT_SFR;
				saddr_nxt = acc_addr[8:0];
			end
		endcase
		// Code memory reached by a legacy data kind is flagged
		if (acc_valid && t == MSAD_TGT_CODE && legacy_data(acc_kind))
			fault_nxt = 1'b1;
		if (!acc_valid)
			t = MSAD_TGT_NONE;
		sel_nxt = 7'h00;
		if (t != MSAD_TGT_NONE)
			sel_nxt[t] = 1'b1;
		bit_nxt = acc_valid && acc_bit && t == MSAD_TGT_RAM &&
			a[15:0] <= MSAD_BIT_LAST;
		wen_nxt = acc_valid && acc_write && t != MSAD_TGT_RSVD &&
			t != MSAD_TGT_CODE;
		maddr_nxt = a;
	end

	// Register file to memory alias
	always_comb
	begin
		rfm_nxt = rf_valid && rf_loc <= MSAD_RF_BANK_LAST;
		rfa_nxt = legacy_internal({3'b000, bank_select_high, bank_select_low,
			rf_loc[2:0]});
	end

	// Decode result registers
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sel_r   <= 7'h00;
			bit_r   <= 1'b0;
			wen_r   <= 1'b0;
			fault_r <= 1'b0;
			maddr_r <= 24'h000000;
			saddr_r <= 9'h000;
			rfm_r   <= 1'b0;
			rfa_r   <= 24'h000000;
		end
		else
		begin
			sel_r   <= sel_nxt;
			bit_r   <= bit_nxt;
			wen_r   <= wen_nxt;
			fault_r <= fault_nxt;
			maddr_r <= maddr_nxt;
			saddr_r <= saddr_nxt;
			rfm_r   <= rfm_nxt;
			rfa_r   <= rfa_nxt;
		end
	end

	// Output mapping; region byte at legacy direct 84 and S:084 is one flop
	assign sel_bank     = sel_r[MSAD_TGT_BANK];
	assign sel_ram      = sel_r[MSAD_TGT_RAM];
	assign sel_code     = sel_r[MSAD_TGT_CODE];
	assign sel_ext      = sel_r[MSAD_TGT_EXT];
	assign sel_sfr      = sel_r[MSAD_TGT_SFR];
	assign sel_rsvd     = sel_r[MSAD_TGT_RSVD];
	assign sel_bit_ok   = bit_r;
	assign sel_write_en = wen_r;
	assign sel_fault    = fault_r;
	assign mem_addr     = maddr_r;
	assign sfr_addr     = saddr_r;
	assign rf_in_mem    = rfm_r;
	assign rf_mem_addr  = rfa_r;
	assign region_byte  = region_r;
	assign fetch_start  = fetch_r;

endmodule

// *** src/msad_pkg.sv ***
package msad_pkg;
	// Address map constants
	localparam logic [7:0]  MSAD_REGION_ZERO     = 8'h00;
	localparam logic [7:0]  MSAD_REGION_ONE      = 8'h01;
	localparam logic [7:0]  MSAD_REGION_FE       = 8'hfe;
	localparam logic [7:0]  MSAD_REGION_TOP      = 8'hff;
	localparam logic [15:0] MSAD_BANK_LAST       = 16'h001f;
	localparam logic [15:0] MSAD_RAM_FIRST       = 16'h0020;
	localparam logic [15:0] MSAD_RAM_LAST        = 16'h041f;
	localparam logic [15:0] MSAD_BIT_LAST        = 16'h007f;
	localparam logic [15:0] MSAD_CODE_LAST       = 16'h3fff;
	localparam logic [15:0] MSAD_BANK_FIRST      = 16'h0000;
	localparam logic [15:0] MSAD_CODE_FIRST      = 16'h0000;
	localparam logic [23:0] MSAD_RESET_FETCH     = 24'hff0000;
	// Legacy space limits
	localparam logic [7:0]  MSAD_LEGACY_SFR_BASE = 8'h80;
	// Register file and special-function locations
	localparam logic [5:0]  MSAD_RF_REGION_LOC   = 6'h39;
	localparam logic [5:0]  MSAD_RF_BANK_LAST    = 6'h07;
	localparam logic [8:0]  MSAD_SFR_REGION_ADDR = 9'h084;
	localparam logic [8:0]  MSAD_SFR_LEGACY_BASE = 9'h080;
	localparam logic [7:0]  MSAD_REGION_RESET    = 8'h01;
	// Geometry the fixed decode serves
	localparam int          MSAD_RF_LOCS         = 64;
	localparam int          MSAD_SFR_LOCS        = 512;
	localparam int          MSAD_BANK_COUNT      = 4;
	// Access kinds
	typedef enum logic [2:0]
	{
		MSAD_ACC_FETCH      = 3'b000,
		MSAD_ACC_DATA       = 3'b001,
		MSAD_ACC_CODE_READ  = 3'b010,
		MSAD_ACC_EXT_MOVE   = 3'b011,
		MSAD_ACC_LEG_DIRECT = 3'b100,
		MSAD_ACC_LEG_INDIR  = 3'b101
	} msad_acc_t;
	// Targets
	typedef enum logic [2:0]
	{
		MSAD_TGT_NONE  = 3'b000,
		MSAD_TGT_BANK  = 3'b001,
		MSAD_TGT_RAM   = 3'b010,
		MSAD_TGT_CODE  = 3'b011,
		MSAD_TGT_EXT   = 3'b100,
		MSAD_TGT_SFR   = 3'b101,
		MSAD_TGT_RSVD  = 3'b110
	} msad_tgt_t;
endpackage

// *** verif/msad_core_model.sv ***
`timescale 1ns/1ps
// Core side: one access at a time
module msad_core_model
(
	input  wire logic        clock,
	output logic             acc_valid,
	output logic [2:0]       acc_kind,
	output logic [23:0]      acc_addr,
	output logic             acc_write,
	output logic             acc_bit,
	output logic [7:0]       acc_wdata
);
	initial {acc_valid, acc_kind, acc_addr, acc_write, acc_bit, acc_wdata} = '0;
	// Default write data for scenarios that do not care
	task automatic access(input logic [2:0] k, input logic [23:0] a, input logic w, b);
		access_wd(k, a, w, b, 8'h5a);
	endtask
	// Held over its taking edge, then released
	task automatic access_wd(input logic [2:0] k, input logic [23:0] a, input logic w, b,
		input logic [7:0] d);
		@(negedge clock);
		{acc_valid, acc_kind, acc_addr, acc_write, acc_bit} = {1'b1, k, a, w, b};
		acc_wdata = d;
		@(negedge clock);
		acc_valid = 1'b0;
		acc_addr = ~a; // No stale address once idle
	endtask
endmodule

// *** verif/msad_decoder_asserts.sv ***
`timescale 1ns/1ps
// Decode relations at the ports
module msad_decoder_asserts
(
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        acc_valid,
	input wire logic [2:0]  acc_kind,
	input wire logic [23:0] acc_addr,
	input wire logic        acc_bit,
	input wire logic        acc_write,
	input wire logic [7:0]  acc_wdata,
	input wire logic        bank_select_high,
	input wire logic        bank_select_low,
	input wire logic        rf_valid,
	input wire logic [5:0]  rf_loc,
	input wire logic        sel_bank,
	input wire logic        sel_ram,
	input wire logic        sel_code,
	input wire logic        sel_ext,
	input wire logic        sel_sfr,
	input wire logic        sel_rsvd,
	input wire logic        sel_bit_ok,
	input wire logic        sel_write_en,
	input wire logic        sel_fault,
	input wire logic [23:0] mem_addr,
	input wire logic [8:0]  sfr_addr,
	input wire logic        rf_in_mem,
	input wire logic [23:0] rf_mem_addr,
	input wire logic [7:0]  region_byte
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	wire region_wr = acc_valid && acc_write && (acc_kind == 3'h4 && acc_addr[7:0] == 8'h84
		|| acc_kind > 3'h5 && acc_addr[8:0] == 9'h084);
	sequence s_ext;
		acc_valid && acc_kind == 3'h3;
	endsequence
	sequence s_region_wr;
		region_wr;
	endsequence
	AST_EXT_ADDR: assert property (s_ext |=> (sel_ext
		|| !($past(region_byte) inside {8'h01, 8'hfe}))
		&& mem_addr == {$past(region_byte), $past(acc_addr[15:0])}) else $error("ext addr");
	AST_REGION_WR: assert property (s_region_wr
		|=> region_byte == $past(acc_wdata)) else $error("region write");
	AST_REGION_HOLD: assert property (!region_wr |=> $stable(region_byte))
		else $error("region changed");
	AST_FAULT: assert property (sel_fault == (sel_code
		&& $past(acc_kind) inside {[3'h3:3'h5]})) else $error("legacy code fault");
	AST_RAM: assert property (acc_valid && acc_kind == 3'h1
		&& acc_addr inside {[24'h000020:24'h00041f]} |=> sel_ram) else $error("ram sel");
	AST_NO_RAM_FETCH: assert property (acc_valid && acc_kind == 3'h0 |=> !sel_ram)
		else $error("fetch from ram");
	AST_RSVD: assert property (acc_valid && acc_kind < 3'h2
		&& acc_addr[23:16] inside {[8'h02:8'hfd]} |=> sel_rsvd && !sel_write_en)
		else $error("reserved");
	AST_LEG_SFR: assert property (acc_valid && acc_kind == 3'h4 && acc_addr[7]
		|=> sel_sfr && sfr_addr == {1'b0, $past(acc_addr[7:0])}) else $error("legacy sfr");
	AST_CODE_RD: assert property (acc_valid && acc_kind == 3'h2
		|=> mem_addr == {8'hff, $past(acc_addr[15:0])}) else $error("code read addr");
	AST_BIT: assert property (acc_valid && acc_bit && acc_kind == 3'h1
		&& acc_addr inside {[24'h000080:24'h00041f]} |=> !sel_bit_ok) else $error("bit");
	AST_BANK: assert property (rf_valid && rf_loc < 6'h08 |=> rf_in_mem
		&& rf_mem_addr == {19'h0, $past(bank_select_high), $past(bank_select_low),
		$past(rf_loc[2:0])}) else $error("bank addr");
	AST_RF_HIDDEN: assert property (rf_valid && rf_loc > 6'h07 |=> !rf_in_mem)
		else $error("rf visible");
	AST_ONE_TGT: assert property ($onehot0({sel_bank, sel_ram, sel_code, sel_ext,
		sel_sfr, sel_rsvd})) else $error("two targets");
endmodule
bind msad_decoder msad_decoder_asserts chk (.*);

// *** verif/msad_decoder_tb.sv ***
`timescale 1ns/1ps
module msad_decoder_tb;
	logic        clock, nrst, external_access_select, acc_valid, acc_write, acc_bit;
	logic        bank_select_high, bank_select_low, rf_valid, sel_bank, sel_ram, sel_code;
	logic        sel_ext, sel_sfr, sel_rsvd, sel_bit_ok, sel_write_en, sel_fault, rf_in_mem;
	logic [2:0]  acc_kind;
	logic [5:0]  rf_loc;
	logic [7:0]  acc_wdata, region_byte;
	logic [8:0]  sfr_addr;
	logic [23:0] acc_addr, mem_addr, rf_mem_addr, fetch_start;
	int          miscompares, comparisons, cycles;
	wire  [5:0]  sel = {sel_bank, sel_ram, sel_code, sel_ext, sel_sfr, sel_rsvd};
	msad_decoder    dut (.*);
	msad_core_model core (.*);
	// Clock
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [23:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic do_reset(input logic s);
		@(negedge clock);
		nrst = 1'b0;
		external_access_select = s;
		repeat (8) @(negedge clock);
		nrst = 1'b1;
		repeat (2) @(negedge clock);
	endtask
	// Reset state and first external move
	task automatic t_reset;
		do_reset(1'b1);
		chk("region", 24'(region_byte), 24'h01);
		chk("start", fetch_start, 24'hff0000);
		core.access(3'h3, 24'h001234, 1'b0, 1'b0);
		chk("ext", mem_addr, 24'h011234);
		$display("t_reset done");
	endtask
	// Target per kind at boundary addresses
	task automatic t_map;
		logic [2:0]  k[13] = '{1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 1, 2};
		logic [23:0] a[13] = '{'h20, 'h41f, 'h420, 'h1f, 'h20000, 'hfdffff, 'h100,
			'h10000, 'hfe0000, 'hff0000, 'hff4000, 'hff3fff, 'h1234};
		logic [5:0]  e[13] = '{'h10, 'h10, 'h04, 'h20, 'h01, 'h01, 'h04, 'h04, 'h04,
			'h08, 'h04, 'h08, 'h08};
		foreach (k[i])
		begin
			core.access(k[i], a[i], 1'b0, 1'b0);
			chk("sel", 24'(sel), 24'(e[i]));
		end
		chk("code", mem_addr, 24'hff1234);
		core.access(3'h1, 24'h030000, 1'b1, 1'b0);
		chk("rsvd_we", 24'({sel_rsvd, sel_write_en}), 24'h2);
		core.access(3'h1, 24'h00007f, 1'b0, 1'b1);
		chk("bit_in", 24'(sel_bit_ok), 24'h1);
		core.access(3'h1, 24'h000080, 1'b0, 1'b1);
		chk("bit_out", 24'(sel_bit_ok), 24'h0);
		$display("t_map done");
	endtask
	// Legacy spaces and region byte write
	task automatic t_legacy;
		core.access(3'h4, 24'h000084, 1'b1, 1'b0);
		chk("sfr", 24'(sfr_addr), 24'h084);
		core.access(3'h3, 24'h00beef, 1'b0, 1'b0);
		chk("ext5a", mem_addr, 24'h5abeef);
		core.access(3'h5, 24'h000090, 1'b0, 1'b0);
		chk("indir", 24'(sel), 24'h10);
		core.access(3'h4, 24'h000030, 1'b0, 1'b0);
		chk("direct", 24'(sel), 24'h10);
		$display("t_legacy done");
	endtask
	// Bank aliasing of the register file
	task automatic t_rf;
		for (int b = 0; b < 4; b++)
		begin
			@(negedge clock);
			{bank_select_high, bank_select_low} = 2'(b);
			rf_valid = 1'b1;
			rf_loc = 6'h03;
			@(negedge clock);
			chk("rf_addr", rf_mem_addr, 24'(b * 8 + 3));
			chk("rf_in", 24'(rf_in_mem), 24'h1);
		end
		rf_loc = 6'h08;
		@(negedge clock);
		chk("rf_hide", 24'(rf_in_mem), 24'h0);
		rf_valid = 1'b0;
		$display("t_rf done");
	endtask
	// Native special-function access, region byte at S:084, legacy code fault
	task automatic t_native;
		core.access_wd(3'h6, 24'h000084, 1'b1, 1'b0, 8'hff);
		chk("nsfr", 24'({sel, sel_write_en}), 24'h05);
		chk("nsfr_addr", 24'(sfr_addr), 24'h084);
		core.access(3'h3, 24'h000100, 1'b0, 1'b0);
		chk("fault", 24'({sel, sel_fault}), 24'h11);
		chk("ext_ff", mem_addr, 24'hff0100);
		core.access(3'h2, 24'h000100, 1'b0, 1'b0);
		chk("no_fault", 24'({sel, sel_fault}), 24'h10);
		core.access_wd(3'h7, 24'h0001ff, 1'b1, 1'b0, 8'h77);
		chk("nsfr_other", 24'({sfr_addr, region_byte}), 24'h1ffff);
		core.access_wd(3'h7, 24'h000084, 1'b1, 1'b0, 8'h01);
		chk("region_back", 24'(region_byte), 24'h01);
		$display("t_native done");
	endtask
	// Strap low sends top fetches outside, even if the pin rises later
	task automatic t_strap;
		do_reset(1'b0);
		external_access_select = 1'b1;
		chk("region", 24'(region_byte), 24'h01);
		core.access(3'h0, 24'hff0000, 1'b0, 1'b0);
		chk("fetch", 24'(sel), 24'h04);
		$display("t_strap done");
	endtask
	task automatic close_out;
		$display("Counts: %0d compared, %0d mismatched", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{nrst, external_access_select, rf_valid, bank_select_high, bank_select_low} = '0;
		rf_loc = '0;
		t_reset;
		t_map;
		t_legacy;
		t_rf;
		t_native;
		t_strap;
		close_out;
	end
endmodule
